// ### rtl/event_flag_latch.sv
`timescale 1ns/1ps
`default_nettype none
module event_flag_latch (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // set and software clear
   input wire logic set_i,
   input wire logic wr_i,
   input wire logic wdata_i,
   // flag
   output logic q_o
);
   logic q_d;
   logic q_q;

   // set wins over a clear in the same cycle
   always_comb begin
      q_d = set_i | (q_q & ~(wr_i & ~wdata_i));
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         q_q <= 1'b0;
      end else begin
         q_q <= q_d;
      end
   end

   assign q_o = q_q;
endmodule
`default_nettype wire

// ### rtl/power_supervisor_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
module power_supervisor_status_regs (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // special function register access
   input wire pwr_sup_pkg::sfr_req_type sfr_i,
   output logic [7:0] sfr_rdata_o,
   // supply monitors
   input wire pwr_sup_pkg::supply_events_type events_i,
   input wire logic switched_supply_source_i,
   input wire logic vdd_ok_i,
   input wire logic vdd_low_i,
   input wire logic pll_unlock_i,
   input wire logic [7:0] power_event_enables_i,
   // sleep and pin
   input wire logic deep_sleep_mode_i,
   input wire logic secondary_uart_rx_i,
   // controls
   output logic switchover_request_o,
   output logic sleep_irq_o,
   output logic sleep_reference_on_o,
   output logic rx_uart_select_o,
   output logic rx_wake_enable_o,
   output logic [3:0] interrupt_pin_config_o
);
   logic [7:0] key_q;
   logic [7:0] key_d;
   logic [7:0] int_pin_q;
   logic [7:0] int_pin_d;
   logic [1:0] policy_q;
   logic [1:0] policy_d;
   logic ref_en_q;
   logic ref_en_d;
   logic [1:0] rx_prog_q;
   logic [1:0] rx_prog_d;
   logic pll_fault_q;
   logic pll_fault_d;
   logic source_q;
   logic rx_q;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic [7:0] flag_set;
   logic [7:0] flags;
   logic wr_flags;
   logic wake_set;
   logic wake_flag;
   logic wr_peripheral_config;
   logic pll_ack;
   logic [7:0] peripheral_config_view;

   function automatic logic hit(input pwr_sup_pkg::sfr_req_type req, input logic [7:0] addr);
      hit = req.wr && (req.addr == addr);
   endfunction

   // event sources for the flag register
   // source edges are taken against the last sample, which resets to main, so no false edge
   always_comb begin
      flag_set = 8'h00;
      flag_set[pwr_sup_pkg::FLAG_RESTORED] = switched_supply_source_i & ~source_q;
      flag_set[pwr_sup_pkg::FLAG_SUMMARY] = |(flags & power_event_enables_i & pwr_sup_pkg::SUMMARY_SRC_MASK);
      flag_set[pwr_sup_pkg::FLAG_SAG] = events_i.sag;
      flag_set[pwr_sup_pkg::FLAG_DCIN_ADC] = events_i.dcin_change | events_i.dcin_ready;
      flag_set[pwr_sup_pkg::FLAG_BATTERY] = events_i.bat_low | events_i.bat_ready;
      flag_set[pwr_sup_pkg::FLAG_SWITCHOVER] = ~switched_supply_source_i & source_q;
      flag_set[pwr_sup_pkg::FLAG_DCIN_LOW] = events_i.dcin_low;
   end

   assign wr_flags = hit(sfr_i, pwr_sup_pkg::ADDR_FLAGS);
   assign wr_peripheral_config = hit(sfr_i, pwr_sup_pkg::ADDR_PERIPHERAL_CONFIG);

   generate
      for (genvar i = 0; i < 8; i++) begin : g_flag
         if (pwr_sup_pkg::FLAGS_MASK[i]) begin : g_real
            event_flag_latch u_flag (
               .clk_sys_i(clk_sys_i),
               .rst_i(rst_i),
               .set_i(flag_set[i]),
               .wr_i(wr_flags),
               .wdata_i(sfr_i.wdata[i]),
               .q_o(flags[i])
            );
         end else begin : g_reserved
            assign flags[i] = 1'b0;
         end
      end
   endgenerate

   // either rx edge wakes; the last sample resets high, the idle level of the pin
   // rx edge wakes deep sleep
   assign wake_set = (secondary_uart_rx_i ^ rx_q) & deep_sleep_mode_i &
                     (rx_prog_q == pwr_sup_pkg::RX_UART_WAKE);

   event_flag_latch u_wake (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .set_i(wake_set),
      .wr_i(wr_peripheral_config),
      .wdata_i(sfr_i.wdata[pwr_sup_pkg::PER_WAKE]),
      .q_o(wake_flag)
   );

   assign pll_ack = hit(sfr_i, pwr_sup_pkg::ADDR_ADC_START) & sfr_i.wdata[pwr_sup_pkg::PLL_ACK_BIT];

   always_comb begin
      peripheral_config_view = {wake_flag, source_q, vdd_ok_i, pll_fault_q, ref_en_q, 1'b0, rx_prog_q};
   end

   // register write path
   always_comb begin
      key_d = key_q;
      int_pin_d = int_pin_q;
      policy_d = policy_q;
      ref_en_d = ref_en_q;
      rx_prog_d = rx_prog_q;
      // the key stays until software rewrites it, so the lock closes again on a write of any value other than the unlock key
      if (hit(sfr_i, pwr_sup_pkg::ADDR_WRITE_KEY)) begin
         key_d = sfr_i.wdata;
      end
      if (hit(sfr_i, pwr_sup_pkg::ADDR_INT_PIN) && key_q == pwr_sup_pkg::UNLOCK_KEY) begin
         int_pin_d = sfr_i.wdata & pwr_sup_pkg::INT_PIN_MASK;
      end
      if (hit(sfr_i, pwr_sup_pkg::ADDR_SWITCHOVER)) begin
         policy_d = sfr_i.wdata[1:0];
      end
      if (wr_peripheral_config) begin
         ref_en_d = sfr_i.wdata[pwr_sup_pkg::PER_REF_EN];
         rx_prog_d = sfr_i.wdata[1:0];
      end
      // unlock wins over ack, so a fault during the acknowledge stays visible
      // fault held until ack
      pll_fault_d = pll_unlock_i | (pll_fault_q & ~pll_ack);
   end

   // read path, answer one cycle after the strobe
   always_comb begin
      rdata_d = rdata_q;
      if (sfr_i.rd) begin
         case (sfr_i.addr)
            pwr_sup_pkg::ADDR_WRITE_KEY: rdata_d = key_q;
            pwr_sup_pkg::ADDR_INT_PIN: rdata_d = int_pin_q;
            pwr_sup_pkg::ADDR_SWITCHOVER: rdata_d = {6'h00, policy_q};
            pwr_sup_pkg::ADDR_FLAGS: rdata_d = flags;
            pwr_sup_pkg::ADDR_PERIPHERAL_CONFIG: rdata_d = peripheral_config_view;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         key_q <= pwr_sup_pkg::KEY_RESET;
         int_pin_q <= pwr_sup_pkg::INT_PIN_RESET;
         policy_q <= pwr_sup_pkg::SWITCH_RESET[1:0];
         ref_en_q <= 1'b0;
         rx_prog_q <= 2'b00;
         pll_fault_q <= 1'b0;
         source_q <= pwr_sup_pkg::SOURCE_RESET;
         rx_q <= 1'b1;
         rdata_q <= 8'h00;
      end else begin
         key_q <= key_d;
         int_pin_q <= int_pin_d;
         policy_q <= policy_d;
         ref_en_q <= ref_en_d;
         rx_prog_q <= rx_prog_d;
         pll_fault_q <= pll_fault_d;
         source_q <= switched_supply_source_i;
         rx_q <= secondary_uart_rx_i;
         rdata_q <= rdata_d;
      end
   end

   always_comb begin
      case (pwr_sup_pkg::policy_type'(policy_q))
         pwr_sup_pkg::POLICY_VDD: switchover_request_o = vdd_low_i;
         pwr_sup_pkg::POLICY_VDD_DCIN: switchover_request_o = vdd_low_i | events_i.dcin_low;
         default: switchover_request_o = 1'b0;
      endcase
   end

   // pin function decode
   // the undefined code 10 falls back to gpio
   always_comb begin
      case (pwr_sup_pkg::rx_function_type'(rx_prog_q))
         pwr_sup_pkg::RX_UART: begin
            rx_uart_select_o = 1'b1;
            rx_wake_enable_o = 1'b0;
         end
         pwr_sup_pkg::RX_UART_WAKE: begin
            rx_uart_select_o = 1'b1;
            rx_wake_enable_o = 1'b1;
         end
         default: begin
            rx_uart_select_o = 1'b0;
            rx_wake_enable_o = 1'b0;
         end
      endcase
   end

   assign sleep_reference_on_o = ~deep_sleep_mode_i | ref_en_q;
   assign sleep_irq_o = flags[pwr_sup_pkg::FLAG_SUMMARY];
   assign interrupt_pin_config_o = int_pin_q[3:0];
   assign sfr_rdata_o = rdata_q;

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);

   sequence s_locked_write;
      hit(sfr_i, pwr_sup_pkg::ADDR_INT_PIN) && key_q != pwr_sup_pkg::UNLOCK_KEY;
   endsequence

   sequence s_unlocked_write;
      hit(sfr_i, pwr_sup_pkg::ADDR_INT_PIN) && key_q == pwr_sup_pkg::UNLOCK_KEY;
   endsequence

   sequence s_read_peripheral_config;
      sfr_i.rd && sfr_i.addr == pwr_sup_pkg::ADDR_PERIPHERAL_CONFIG;
   endsequence

   sequence s_wake_armed;
      deep_sleep_mode_i && rx_prog_q == 2'b11 && secondary_uart_rx_i != rx_q;
   endsequence

   chk_pin_locked: assert property (s_locked_write |=> $stable(int_pin_q))
      else $error("pin config changed while locked");
   chk_pin_unlocked: assert property (s_unlocked_write |=> int_pin_q == ($past(sfr_i.wdata) & 8'h0f))
      else $error("pin config not written with key");
   chk_restore_flag: assert property ($rose(switched_supply_source_i) |=> flags[7])
      else $error("restore flag missing");
   chk_summary_set: assert property (|(flags & power_event_enables_i & 8'haf) |=> flags[6])
      else $error("summary flag missing");
   chk_summary_gate: assert property (!flags[6] && !(|(flags & power_event_enables_i & 8'haf)) |=> !flags[6])
      else $error("summary flag without enabled event");
   chk_sag_flag: assert property (events_i.sag |=> flags[5])
      else $error("sag flag missing");
   chk_dcin_flag: assert property (events_i.dcin_change || events_i.dcin_ready |=> flags[3])
      else $error("dcin adc flag missing");
   chk_bat_flag: assert property (events_i.bat_low || events_i.bat_ready |=> flags[2])
      else $error("battery flag missing");
   chk_switch_flag: assert property ($fell(switched_supply_source_i) |=> flags[1])
      else $error("switchover flag missing");
   chk_dcin_low_flag: assert property (events_i.dcin_low |=> flags[0])
      else $error("dcin low flag missing");
   chk_policy_off: assert property (policy_q[1] |-> !switchover_request_o)
      else $error("switchover while disabled");
   chk_source_read: assert property (sfr_i.rd && sfr_i.addr == 8'hf4 |=> sfr_rdata_o[6] == $past(source_q))
      else $error("source bit mismatch");
   chk_pll_hold: assert property (pll_fault_q && !pll_ack |=> pll_fault_q)
      else $error("pll fault dropped without ack");
   chk_pll_ack: assert property (pll_ack && !pll_unlock_i |=> !pll_fault_q)
      else $error("pll fault not cleared by ack");
   chk_wake_flag: assert property (wake_set |=> wake_flag)
      else $error("wake flag missing");
   chk_flag_clear: assert property (wr_flags && !sfr_i.wdata[5] && !events_i.sag |=> !flags[5])
      else $error("flag not cleared by zero write");

   chk_flag_sticky: assert property (flags[5] && !(wr_flags && !sfr_i.wdata[5]) |=> flags[5])
      else $error("flag dropped without zero write");
   chk_policy_vdd: assert property (policy_q == 2'b00 |-> switchover_request_o == vdd_low_i)
      else $error("switchover not following low supply");
   chk_policy_dcin: assert property (policy_q == 2'b01 |->
      switchover_request_o == (vdd_low_i || events_i.dcin_low))
      else $error("switchover not following low supply or low dcin");
   chk_rx_gpio: assert property (!rx_prog_q[0] |-> !rx_uart_select_o && !rx_wake_enable_o)
      else $error("pin not released to gpio");
   chk_rx_uart: assert property (rx_prog_q == 2'b01 |-> rx_uart_select_o && !rx_wake_enable_o)
      else $error("uart receive without wake not selected");
   chk_rx_wake: assert property (rx_prog_q == 2'b11 |-> rx_uart_select_o && rx_wake_enable_o)
      else $error("uart receive with wake not selected");
   chk_ref_sleep: assert property (deep_sleep_mode_i && ref_en_q |-> sleep_reference_on_o)
      else $error("reference off in deep sleep");
   chk_ready_read: assert property (s_read_peripheral_config |=> sfr_rdata_o[5] == $past(vdd_ok_i))
      else $error("supply ready bit mismatch");
   chk_wake_read: assert property (s_read_peripheral_config |=> sfr_rdata_o[7] == $past(wake_flag))
      else $error("wake bit mismatch");
   chk_wake_edge: assert property (s_wake_armed |=> wake_flag)
      else $error("armed rx edge did not wake");
   chk_wake_gate: assert property (!wake_flag && rx_prog_q != 2'b11 |=> !wake_flag)
      else $error("wake flag without wake function");
   chk_wake_hold: assert property (wake_flag && !(wr_peripheral_config && !sfr_i.wdata[7]) |=> wake_flag)
      else $error("wake flag dropped without zero write");
   chk_pll_set: assert property (pll_unlock_i |=> pll_fault_q)
      else $error("pll fault not raised on unlock");
   chk_key_hold: assert property (!hit(sfr_i, pwr_sup_pkg::ADDR_WRITE_KEY) |=> $stable(key_q))
      else $error("key changed without a key write");
endmodule
`default_nettype wire

// ### rtl/pwr_sup_pkg.sv
// Operation
// - interrupt pin config writes need unlock key
// - flag 7 sets on battery-to-main return
// - flag 6 sets on any enabled event
// - flag 5 sets on voltage sag
// - flag 3 sets on dcin change or ready
// - flag 2 sets on battery low or ready
// - flag 1 sets on main-to-battery switchover
// - flag 0 sets on dcin below threshold
// - policy field selects switchover condition
// - peripheral bit 6 shows live supply source
// - peripheral bit 5 shows main supply ready
// - peripheral bit 7 flags uart wake-up
// - pll fault bit held until acknowledge
// - peripheral bit 3 keeps reference in sleep
// - pin function field selects gpio or uart
// - summary only from enabled event flags
package pwr_sup_pkg;
   // register addresses
   localparam logic [7:0] ADDR_WRITE_KEY = 8'hc1;
   localparam logic [7:0] ADDR_PERIPHERAL_CONFIG = 8'hf4;
   localparam logic [7:0] ADDR_SWITCHOVER = 8'hf5;
   localparam logic [7:0] ADDR_FLAGS = 8'hf8;
   localparam logic [7:0] ADDR_INT_PIN = 8'hff;
   localparam logic [7:0] ADDR_ADC_START = 8'hd8;
   localparam logic [7:0] UNLOCK_KEY = 8'hea;
   // flag bit positions
   localparam int FLAG_RESTORED = 7;
   localparam int FLAG_SUMMARY = 6;
   localparam int FLAG_SAG = 5;
   localparam int FLAG_DCIN_ADC = 3;
   localparam int FLAG_BATTERY = 2;
   localparam int FLAG_SWITCHOVER = 1;
   localparam int FLAG_DCIN_LOW = 0;
   // peripheral bit positions
   localparam int PER_WAKE = 7;
   localparam int PER_SOURCE = 6;
   localparam int PER_VDD_OK = 5;
   localparam int PER_PLL_FAULT = 4;
   localparam int PER_REF_EN = 3;
   localparam int PLL_ACK_BIT = 7;
   // writable and readable masks
   localparam logic [7:0] FLAGS_MASK = 8'hef;
   localparam logic [7:0] SUMMARY_SRC_MASK = 8'haf;
   localparam logic [7:0] SWITCH_MASK = 8'h03;
   localparam logic [7:0] INT_PIN_MASK = 8'h0f;
   // reset values
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] SWITCH_RESET = 8'h00;
   localparam logic [7:0] INT_PIN_RESET = 8'h00;
   localparam logic [7:0] KEY_RESET = 8'h00;
   localparam logic SOURCE_RESET = 1'b1;

   typedef enum logic [1:0] {
      POLICY_VDD = 2'b00,
      POLICY_VDD_DCIN = 2'b01,
      POLICY_OFF_LO = 2'b10,
      POLICY_OFF_HI = 2'b11
   } policy_type;

   typedef enum logic [1:0] {
      RX_GPIO = 2'b00,
      RX_UART = 2'b01,
      RX_UNDEF = 2'b10,
      RX_UART_WAKE = 2'b11
   } rx_function_type;

   typedef struct packed {
      logic sag;
      logic dcin_change;
      logic dcin_ready;
      logic bat_low;
      logic bat_ready;
      logic dcin_low;
   } supply_events_type;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_type;
endpackage

// ### test/power_supervisor_status_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module power_supervisor_status_regs_tb;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   pwr_sup_pkg::sfr_req_type sfr_i = '0;
   pwr_sup_pkg::supply_events_type events_i = '0;
   logic src_i = 1'b1;
   logic vdd_ok_i = 1'b1;
   logic vdd_low_i = 1'b0;
   logic pll_i = 1'b0;
   logic sleep_i = 1'b0;
   logic rx_i = 1'b1;
   logic [7:0] en_i = 8'h00;
   logic [7:0] rdata;
   logic swreq, irq, refon, usel, wake_en;
   logic [3:0] pin;
   int num_errors = 0;
   int cmp_count = 0;
   int seed = 72;
   int cycles = 0;
   int fb[6] = '{0, 2, 2, 3, 3, 5};
   logic [7:0] v, e;
   logic r;

   always #2 clk_sys_i = ~clk_sys_i;

   power_supervisor_status_regs uut (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .sfr_i(sfr_i), .sfr_rdata_o(rdata),
      .events_i(events_i), .switched_supply_source_i(src_i), .vdd_ok_i(vdd_ok_i),
      .vdd_low_i(vdd_low_i), .pll_unlock_i(pll_i), .power_event_enables_i(en_i),
      .deep_sleep_mode_i(sleep_i), .secondary_uart_rx_i(rx_i),
      .switchover_request_o(swreq), .sleep_irq_o(irq), .sleep_reference_on_o(refon),
      .rx_uart_select_o(usel), .rx_wake_enable_o(wake_en), .interrupt_pin_config_o(pin)
   );

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   // one-cycle write strobe, released at the next falling edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys_i);
      sfr_i = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge clk_sys_i);
      sfr_i.wr = 1'b0;
   endtask

   // read data is registered, so it is settled one falling edge later
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
      @(negedge clk_sys_i);
      sfr_i = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge clk_sys_i);
      sfr_i.rd = 1'b0;
      chk(name, exp, rdata);
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask

   function automatic logic [7:0] per_exp(input logic w, input logic s, input logic p, input logic f,
                                          input logic [1:0] x);
      return {w, s, vdd_ok_i, p, f, 1'b0, x};
   endfunction

   function automatic logic swreq_exp(input logic [1:0] p, input logic lo, input logic dc);
      return p[1] ? 1'b0 : (lo | (p[0] & dc));
   endfunction

   task automatic print_verdict;
      $display("counts: %0d comparisons, %0d mismatches", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // generous ceiling: the whole sequence needs well under a thousand cycles
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         print_verdict();
      end
   end

   initial begin
      idle(10);
      rst_i = 1'b0;
      rd(pwr_sup_pkg::ADDR_FLAGS, 8'h00, "flags reset");
      rd(pwr_sup_pkg::ADDR_SWITCHOVER, 8'h00, "switchover reset");
      rd(pwr_sup_pkg::ADDR_PERIPHERAL_CONFIG, per_exp(0, 1, 0, 0, 2'b00), "peripheral_config reset");
      rd(8'hfb, 8'h00, "unmapped");
      $display("test reset done");
      v = 8'($random(seed)) | 8'h01;
      wr(pwr_sup_pkg::ADDR_INT_PIN, 8'h05);
      rd(pwr_sup_pkg::ADDR_INT_PIN, 8'h00, "pin locked");
      wr(pwr_sup_pkg::ADDR_WRITE_KEY, pwr_sup_pkg::UNLOCK_KEY);
      wr(pwr_sup_pkg::ADDR_INT_PIN, v);
      rd(pwr_sup_pkg::ADDR_INT_PIN, v & 8'h0f, "pin unlocked");
      chk("pin out", v & 8'h0f, {4'h0, pin});
      wr(pwr_sup_pkg::ADDR_WRITE_KEY, 8'h00);
      wr(pwr_sup_pkg::ADDR_INT_PIN, ~v);
      rd(pwr_sup_pkg::ADDR_INT_PIN, v & 8'h0f, "pin relocked");
      rd(pwr_sup_pkg::ADDR_WRITE_KEY, 8'h00, "key");
      $display("test key done");
      for (int i = 0; i < 6; i++) begin
         en_i = 8'($random(seed));
         @(negedge clk_sys_i);
         events_i = 6'(1 << i);
         @(negedge clk_sys_i);
         events_i = '0;
         idle(2);
         e = 8'(1 << fb[i]);
         e[6] = en_i[fb[i]];
         rd(pwr_sup_pkg::ADDR_FLAGS, e, "event flag");
         chk("irq", {7'h0, e[6]}, {7'h0, irq});
         wr(pwr_sup_pkg::ADDR_FLAGS, 8'hef);
         rd(pwr_sup_pkg::ADDR_FLAGS, e, "flag held");
         en_i = 8'h00;
         wr(pwr_sup_pkg::ADDR_FLAGS, 8'h00);
         rd(pwr_sup_pkg::ADDR_FLAGS, 8'h00, "flag cleared");
      end
      $display("test events done");
      src_i = 1'b0;
      vdd_ok_i = 1'b0;
      idle(4);
      rd(pwr_sup_pkg::ADDR_FLAGS, 8'h02, "to battery");
      rd(pwr_sup_pkg::ADDR_PERIPHERAL_CONFIG, per_exp(0, 0, 0, 0, 2'b00), "peripheral_config battery");
      src_i = 1'b1;
      vdd_ok_i = 1'b1;
      idle(4);
      rd(pwr_sup_pkg::ADDR_FLAGS, 8'h82, "to main");
      wr(pwr_sup_pkg::ADDR_FLAGS, 8'h00);
      $display("test source done");
      for (int p = 0; p < 4; p++) begin
         wr(pwr_sup_pkg::ADDR_SWITCHOVER, 8'(p));
         rd(pwr_sup_pkg::ADDR_SWITCHOVER, 8'(p), "policy");
         for (int k = 0; k < 4; k++) begin
            {vdd_low_i, events_i.dcin_low} = 2'(k);
            @(negedge clk_sys_i);
            chk("swreq", {7'h0, swreq_exp(2'(p), vdd_low_i, events_i.dcin_low)}, {7'h0, swreq});
         end
         {vdd_low_i, events_i.dcin_low} = 2'b00;
      end
      wr(pwr_sup_pkg::ADDR_SWITCHOVER, 8'h00);
      wr(pwr_sup_pkg::ADDR_FLAGS, 8'h00);
      $display("test policy done");
      for (int x = 0; x < 4; x++) begin
         r = 1'($random(seed));
         wr(pwr_sup_pkg::ADDR_PERIPHERAL_CONFIG, {4'h0, r, 1'b0, 2'(x)});
         rd(pwr_sup_pkg::ADDR_PERIPHERAL_CONFIG, per_exp(0, 1, 0, r, 2'(x)), "peripheral_config cfg");
         for (int d = 0; d < 2; d++) begin
            sleep_i = 1'(d);
            @(negedge clk_sys_i);
            chk("ref on", {7'h0, ~sleep_i | r}, {7'h0, refon});
            chk("uart sel", {7'h0, x == 1 || x == 3}, {7'h0, usel});
            chk("wake en", {7'h0, x == 3}, {7'h0, wake_en});
         end
      end
      $display("test peripheral_config done");
      wr(pwr_sup_pkg::ADDR_PERIPHERAL_CONFIG, 8'h03);
      sleep_i = 1'b1;
      rx_i = 1'b0;
      idle(3);
      rd(pwr_sup_pkg::ADDR_PERIPHERAL_CONFIG, per_exp(1, 1, 0, 0, 2'b11), "wake set");
      wr(pwr_sup_pkg::ADDR_PERIPHERAL_CONFIG, 8'h01);
      rx_i = 1'b1;
      idle(3);
      rd(pwr_sup_pkg::ADDR_PERIPHERAL_CONFIG, per_exp(0, 1, 0, 0, 2'b01), "no wake");
      sleep_i = 1'b0;
      $display("test wake done");
      pll_i = 1'b1;
      @(negedge clk_sys_i);
      pll_i = 1'b0;
      idle(3);
      rd(pwr_sup_pkg::ADDR_PERIPHERAL_CONFIG, per_exp(0, 1, 1, 0, 2'b01), "pll fault");
      wr(pwr_sup_pkg::ADDR_ADC_START, 8'h7f);
      rd(pwr_sup_pkg::ADDR_PERIPHERAL_CONFIG, per_exp(0, 1, 1, 0, 2'b01), "pll held");
      wr(pwr_sup_pkg::ADDR_ADC_START, 8'h80);
      rd(pwr_sup_pkg::ADDR_PERIPHERAL_CONFIG, per_exp(0, 1, 0, 0, 2'b01), "pll ack");
      $display("test pll done");
      print_verdict();
   end
endmodule
`default_nettype wire
